// *** rtl/csr_pkg.sv ***
// shared constants and types of the core special register block
package csr_pkg;
  // special register locations, identical in both banks
  localparam logic [7:0] A_PORT0   = 8'h00;
  localparam logic [7:0] A_PTR0    = 8'h01;
  localparam logic [7:0] A_PORT1   = 8'h02;
  localparam logic [7:0] A_PTR1    = 8'h03;
  localparam logic [7:0] A_BANK    = 8'h04;
  localparam logic [7:0] A_ACCU    = 8'h05;
  localparam logic [7:0] A_PCLO    = 8'h06;
  localparam logic [7:0] A_TPTR    = 8'h07;
  localparam logic [7:0] A_THI     = 8'h08;
  localparam logic [7:0] A_STATUS  = 8'h0A;
  localparam logic [7:0] A_GP_BASE = 8'h40;
  // status field positions
  localparam int B_C    = 0;
  localparam int B_HC   = 1;
  localparam int B_Z    = 2;
  localparam int B_OVF  = 3;
  localparam int B_PWD  = 4;
  localparam int B_WTO  = 5;
  localparam int B_BANK = 0;
  // masks and reset values
  localparam logic [7:0]  BANK_MASK = 8'h01;
  localparam logic [7:0]  ST_WMASK  = 8'h0F;
  localparam logic [7:0]  RST_BANK  = 8'h00;
  localparam logic [7:0]  RST_ST    = 8'h00;
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam int          PC_W      = 11;
  localparam logic [10:0] RST_PC    = 11'h000;
  localparam int          RAM_AW    = 7;
  localparam int          PM_W      = 15;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_ADD  = 3'h1,
    OP_SUB  = 3'h2,
    OP_AND  = 3'h3,
    OP_OR   = 3'h4,
    OP_XOR  = 3'h5,
    OP_RRC  = 3'h6,
    OP_RLC  = 3'h7
  } csr_alu_op_t;

  typedef enum logic [1:0] {
    TS_IDLE  = 2'h0,
    TS_FETCH = 2'h1,
    TS_STORE = 2'h3
  } csr_tbl_state_t;
endpackage : csr_pkg

// *** rtl/csr_mem_if.sv ***
// data memory port between the register block and its ram
`timescale 1ns/1ps
interface csr_mem_if;
  import csr_pkg::*;
  logic              we;
  logic              re;
  logic [RAM_AW-1:0] addr;
  logic [7:0]        wdata;
  logic [7:0]        rdata;
  modport ctrl (output we, re, addr, wdata, input rdata);
  modport mem  (input we, re, addr, wdata, output rdata);
endinterface : csr_mem_if

// *** rtl/csr_data_ram.sv ***
// general purpose data memory for both banks, registered read
`timescale 1ns/1ps
module csr_data_ram
  import csr_pkg::*;
(
  input  wire logic i_clk_sys, // system clock
  csr_mem_if.mem    mem        // data port
);
  logic [7:0] store [2**RAM_AW];

  always_ff @(posedge i_clk_sys) begin
    if (mem.we) begin
      store[mem.addr] <= mem.wdata;
    end
    if (mem.re) begin
      mem.rdata <= store[mem.addr];
    end
  end
endmodule : csr_data_ram

// *** rtl/csr_addr_resolve.sv ***
// turns an operand address into effective location, bank and kind
`timescale 1ns/1ps
module csr_addr_resolve
  import csr_pkg::*;
(
  input  wire logic [7:0] i_addr, // operand address
  input  wire logic [7:0] i_mp0,  // first memory pointer
  input  wire logic [7:0] i_mp1,  // second memory pointer
  input  wire logic       i_bank, // bank select bit
  output logic      [7:0] o_addr, // effective address
  output logic            o_bank, // effective bank
  output logic            o_sfr,  // lands in special area
  output logic            o_null  // pointer aims at a port itself
);
  logic ind;

  always_comb begin
    o_bank = 1'h0;
    o_addr = i_addr;
    ind    = 1'h1;
    case (i_addr)
      A_PORT0: o_addr = i_mp0;
      A_PORT1: begin
        o_addr = i_mp1;
        o_bank = i_bank;
      end
      default: ind = 1'h0;
    endcase
  end

  // special area decodes the same in every bank; nonvolatile memory has no cell here
  assign o_sfr  = o_addr < A_GP_BASE;
  assign o_null = ind && (o_addr == A_PORT0 || o_addr == A_PORT1);
endmodule : csr_addr_resolve

// *** rtl/csr_core_regs.sv ***
// core special registers: bank select, status, pc low, table read, accumulator
`timescale 1ns/1ps
// Operation
// - bank select bit 0 picks data bank 0 when zero, bank 1 when one.
// - any reset returns bank 0, except watchdog reset while powered down.
// - special register area decodes identically in every bank.
// - direct addresses always reach bank 0 regardless of bank select.
// - bank 1 is reached only through the indirect path.
// - unused upper bits of bank select and status read zero.
// - writing the pc low byte jumps within the current page.
// - a pc low write inserts one dummy instruction cycle.
// - table read loads high byte to table high, low byte to named spot.
// - status writes never change watchdog or power-down flags.
// - watchdog flag set on time-out; cleared by power-up, clear, halt.
// - power-down flag set by halt; cleared by power-up or watchdog clear.
// - carry set on add carry or no subtract borrow; rotates update it.
// - half carry reflects low nibble carry or no low nibble borrow.
// - zero flag set when arithmetic or logic result is zero.
// - overflow set when carry into and out of bit 7 differ.
// - status is never saved automatically on interrupt or call.
// - no register-to-register move; all unit results land in accumulator.
// - nonvolatile data memory stays outside the direct address map.
// - second pointer port reaches any bank, first port bank 0 only.
// - unused special locations read zero.
module csr_core_regs
  import csr_pkg::*;
(
  input  wire logic             i_clk_sys,          // system clock
  input  wire logic             i_reset,            // power-up reset
  input  wire logic             i_soft_reset,       // other reset pulse
  input  wire logic             i_wdt_pd_reset,     // that reset is a sleep time-out
  input  wire logic             i_wdt_timeout,      // watchdog time-out event
  input  wire logic             i_watchdog_clear_instruction,          // watchdog clear instruction
  input  wire logic             i_halt,             // halt instruction
  input  wire logic             i_acc_req,          // data memory access
  input  wire logic             i_acc_wr,           // access is a write
  input  wire logic [7:0]       i_acc_addr,         // operand address
  input  wire logic [7:0]       i_acc_wdata,        // write data
  input  wire csr_alu_op_t      i_alu_op,           // unit operation
  input  wire logic [7:0]       i_alu_b,            // second operand
  input  wire logic             i_step,             // instruction advance
  input  wire logic             i_tblrd,            // table read instruction
  input  wire logic             i_tbl_to_acc,       // low byte goes to accumulator
  input  wire logic [PM_W-1:0]  i_pmem_data,        // program word
  output logic      [7:0]       o_rd_data,          // read data
  output logic                  o_rd_valid,         // read data strobe
  output logic      [PC_W-1:0]  o_pmem_addr,        // table fetch address
  output logic                  o_pmem_rd,          // table fetch strobe
  output logic      [PC_W-1:0]  o_pc,               // program counter
  output logic                  o_dummy_cycle,      // inserted idle cycle
  output logic      [7:0]       o_work_accumulator, // accumulator
  output logic      [7:0]       o_status            // status register
);
  logic [7:0]      data_bank_select;
  logic [7:0]      memory_pointer_0;
  logic [7:0]      memory_pointer_1;
  logic [7:0]      work_accumulator;
  logic [PC_W-1:0] program_counter;
  logic [7:0]      table_pointer;
  logic [7:0]      table_high_byte;
  logic [7:0]      core_status_flags;
  logic            dummy;
  logic [PC_W-1:0] pmem_addr;
  logic            pmem_rd;
  csr_tbl_state_t  tbl_state;
  logic            tbl_to_acc;
  logic [7:0]      tbl_dst;

  logic [7:0]      next_data_bank_select;
  logic [7:0]      next_memory_pointer_0;
  logic [7:0]      next_memory_pointer_1;
  logic [7:0]      next_work_accumulator;
  logic [PC_W-1:0] next_program_counter;
  logic [7:0]      next_table_pointer;
  logic [7:0]      next_table_high_byte;
  logic [7:0]      next_core_status_flags;
  logic            next_dummy;
  logic [PC_W-1:0] next_pmem_addr;
  logic            next_pmem_rd;
  csr_tbl_state_t  next_tbl_state;
  logic            next_tbl_to_acc;
  logic [7:0]      next_tbl_dst;

  logic            rd_p1;
  logic            rd_ram;
  logic [7:0]      rd_sfr;
  logic            next_rd_p1;
  logic            next_rd_ram;
  logic [7:0]      next_rd_sfr;
  logic [7:0]      next_rd_data;
  logic            next_rd_valid;

  logic [7:0]      eff_addr;
  logic            eff_bank;
  logic            eff_sfr;
  logic            eff_null;
  logic            acc_wr;
  logic            acc_rd;
  logic            sfr_wr;
  logic [10:0]     ev;
  logic            alu_arith;
  logic            alu_logic;
  logic            alu_rot;

  csr_mem_if mem ();

  csr_data_ram u_ram (
    .i_clk_sys (i_clk_sys),
    .mem       (mem.mem)
  );

  csr_addr_resolve u_res (
    .i_addr (i_acc_addr),
    .i_mp0  (memory_pointer_0),
    .i_mp1  (memory_pointer_1),
    .i_bank (data_bank_select[B_BANK]),
    .o_addr (eff_addr),
    .o_bank (eff_bank),
    .o_sfr  (eff_sfr),
    .o_null (eff_null)
  );

  // returns {carry, half carry, overflow, result}
  function automatic logic [10:0] alu_eval(input csr_alu_op_t op,
                                           input logic [7:0]  a,
                                           input logic [7:0]  b,
                                           input logic        cin);
    logic [7:0] bb;
    logic       ci;
    logic [8:0] sum;
    logic [4:0] low;
    logic [7:0] sev;
    bb  = (op == OP_SUB) ? ~b : b;
    ci  = (op == OP_SUB);
    sum = {1'h0, a} + {1'h0, bb} + {8'h00, ci};
    low = {1'h0, a[3:0]} + {1'h0, bb[3:0]} + {4'h0, ci};
    sev = {1'h0, a[6:0]} + {1'h0, bb[6:0]} + {7'h00, ci};
    case (op)
      OP_ADD, OP_SUB: alu_eval = {sum[8], low[4], sev[7] ^ sum[8], sum[7:0]};
      OP_AND:         alu_eval = {cin, 2'h0, a & b};
      OP_OR:          alu_eval = {cin, 2'h0, a | b};
      OP_XOR:         alu_eval = {cin, 2'h0, a ^ b};
      OP_RRC:         alu_eval = {a[0], 2'h0, cin, a[7:1]};
      OP_RLC:         alu_eval = {a[7], 2'h0, a[6:0], cin};
      default:        alu_eval = {cin, 2'h0, a};
    endcase
  endfunction : alu_eval

  // indirect access to a port itself reads zero and writes nothing
  assign acc_wr    = i_acc_req && i_acc_wr && !eff_null;
  assign acc_rd    = i_acc_req && !i_acc_wr;
  assign sfr_wr    = acc_wr && eff_sfr;
  assign alu_arith = (i_alu_op == OP_ADD) || (i_alu_op == OP_SUB);
  assign alu_logic = (i_alu_op == OP_AND) || (i_alu_op == OP_OR) || (i_alu_op == OP_XOR);
  assign alu_rot   = (i_alu_op == OP_RRC) || (i_alu_op == OP_RLC);
  assign ev = alu_eval(i_alu_op, work_accumulator, i_alu_b, core_status_flags[B_C]);

  always_comb begin
    next_data_bank_select  = data_bank_select;
    next_memory_pointer_0  = memory_pointer_0;
    next_memory_pointer_1  = memory_pointer_1;
    next_work_accumulator  = work_accumulator;
    next_program_counter   = program_counter;
    next_table_pointer     = table_pointer;
    next_table_high_byte   = table_high_byte;
    next_core_status_flags = core_status_flags;
    next_dummy             = 1'h0;
    next_pmem_addr         = pmem_addr;
    next_pmem_rd           = 1'h0;
    next_tbl_state         = tbl_state;
    next_tbl_to_acc        = tbl_to_acc;
    next_tbl_dst           = tbl_dst;

    // the pc stalls for the dummy cycle after a jump
    if (i_step && !dummy) begin
      next_program_counter = PC_W'(program_counter + 1'h1);
    end

    // every unit result lands in the accumulator only
    if (i_alu_op != OP_NONE) begin
      next_work_accumulator = ev[7:0];
    end
    if (alu_arith) begin
      next_core_status_flags[B_C]  = ev[10];
      next_core_status_flags[B_HC]  = ev[9];
      next_core_status_flags[B_OVF] = ev[8];
    end
    if (alu_rot) begin
      next_core_status_flags[B_C] = ev[10];
    end
    if (alu_arith || alu_logic) begin
      next_core_status_flags[B_Z] = (ev[7:0] == 8'h00);
    end

    if (sfr_wr) begin
      case (eff_addr)
        A_PTR0: next_memory_pointer_0 = i_acc_wdata;
        A_PTR1: next_memory_pointer_1 = i_acc_wdata;
        A_BANK: begin
          next_data_bank_select = i_acc_wdata & BANK_MASK;
        end
        A_ACCU: next_work_accumulator = i_acc_wdata;
        A_PCLO: begin
          next_program_counter = {program_counter[PC_W-1:8], i_acc_wdata};
          next_dummy           = 1'h1;
        end
        A_TPTR: next_table_pointer = i_acc_wdata;
        A_STATUS: begin
          next_core_status_flags = (next_core_status_flags & ~ST_WMASK)
                                 | (i_acc_wdata & ST_WMASK);
        end
        default: begin
          next_dummy = 1'h0;
        end
      endcase
    end

    // status is only held here; nothing stacks it on call or interrupt
    if (i_watchdog_clear_instruction) begin
      next_core_status_flags[B_WTO] = 1'h0;
      next_core_status_flags[B_PWD] = 1'h0;
    end
    if (i_halt) begin
      next_core_status_flags[B_WTO] = 1'h0;
      next_core_status_flags[B_PWD] = 1'h1;
    end
    // a time-out in the same cycle as a clear still sets the flag
    if (i_wdt_timeout) begin
      next_core_status_flags[B_WTO] = 1'h1;
    end

    case (tbl_state)
      TS_IDLE: begin
        if (i_tblrd) begin
          next_pmem_addr  = {program_counter[PC_W-1:8], table_pointer};
          next_pmem_rd    = 1'h1;
          next_tbl_to_acc = i_tbl_to_acc;
          next_tbl_dst    = i_acc_addr;
          next_tbl_state  = TS_FETCH;
        end
      end
      TS_FETCH: begin
        next_tbl_state = TS_STORE;
      end
      TS_STORE: begin
        next_table_high_byte = {1'h0, i_pmem_data[PM_W-1:8]};
        if (tbl_to_acc) begin
          next_work_accumulator = i_pmem_data[7:0];
        end
        next_tbl_state = TS_IDLE;
      end
      default: begin
        next_tbl_state = TS_IDLE;
      end
    endcase

    // other resets; a sleep time-out keeps the bank selection
    if (i_soft_reset) begin
      next_program_counter = RST_PC;
      next_tbl_state       = TS_IDLE;
      next_pmem_rd         = 1'h0;
      if (!i_wdt_pd_reset) begin
        next_data_bank_select = RST_BANK;
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      data_bank_select  <= RST_BANK;
      memory_pointer_0  <= RST_BYTE;
      memory_pointer_1  <= RST_BYTE;
      work_accumulator  <= RST_BYTE;
      program_counter   <= RST_PC;
      table_pointer     <= RST_BYTE;
      table_high_byte   <= RST_BYTE;
      core_status_flags <= RST_ST;
      dummy             <= 1'h0;
      pmem_addr         <= RST_PC;
      pmem_rd           <= 1'h0;
      tbl_state         <= TS_IDLE;
      tbl_to_acc        <= 1'h0;
      tbl_dst           <= RST_BYTE;
    end else begin
      data_bank_select  <= next_data_bank_select;
      memory_pointer_0  <= next_memory_pointer_0;
      memory_pointer_1  <= next_memory_pointer_1;
      work_accumulator  <= next_work_accumulator;
      program_counter   <= next_program_counter;
      table_pointer     <= next_table_pointer;
      table_high_byte   <= next_table_high_byte;
      core_status_flags <= next_core_status_flags;
      dummy             <= next_dummy;
      pmem_addr         <= next_pmem_addr;
      pmem_rd           <= next_pmem_rd;
      tbl_state         <= next_tbl_state;
      tbl_to_acc        <= next_tbl_to_acc;
      tbl_dst           <= next_tbl_dst;
    end
  end

  // data ram port; the table store takes the port in its own cycle
  always_comb begin
    mem.we    = acc_wr && !eff_sfr;
    mem.re    = acc_rd && !eff_sfr;
    mem.addr  = {eff_bank, eff_addr[RAM_AW-2:0]};
    mem.wdata = i_acc_wdata;
    if (tbl_state == TS_STORE && !tbl_to_acc) begin
      mem.we    = 1'h1;
      mem.re    = 1'h0;
      mem.addr  = {1'h0, tbl_dst[RAM_AW-2:0]};
      mem.wdata = i_pmem_data[7:0];
    end
  end

  // read path: capture in cycle 1, present in cycle 2
  always_comb begin
    next_rd_p1  = acc_rd;
    next_rd_ram = !eff_sfr && !eff_null;
    next_rd_sfr = 8'h00;
    if (!eff_null) begin
      case (eff_addr)
        A_PTR0:   next_rd_sfr = memory_pointer_0;
        A_PTR1:   next_rd_sfr = memory_pointer_1;
        A_BANK:   next_rd_sfr = data_bank_select;
        A_ACCU:   next_rd_sfr = work_accumulator;
        A_PCLO:   next_rd_sfr = program_counter[7:0];
        A_TPTR:   next_rd_sfr = table_pointer;
        A_THI:    next_rd_sfr = table_high_byte;
        A_STATUS: next_rd_sfr = core_status_flags;
        default:  next_rd_sfr = 8'h00;
      endcase
    end
    next_rd_data  = rd_ram ? mem.rdata : rd_sfr;
    next_rd_valid = rd_p1;
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      rd_p1      <= 1'h0;
      rd_ram     <= 1'h0;
      rd_sfr     <= 8'h00;
      o_rd_data  <= 8'h00;
      o_rd_valid <= 1'h0;
    end else begin
      rd_p1      <= next_rd_p1;
      rd_ram     <= next_rd_ram;
      rd_sfr     <= next_rd_sfr;
      o_rd_data  <= next_rd_data;
      o_rd_valid <= next_rd_valid;
    end
  end

  assign o_pmem_addr        = pmem_addr;
  assign o_pmem_rd          = pmem_rd;
  assign o_pc               = program_counter;
  assign o_dummy_cycle      = dummy;
  assign o_work_accumulator = work_accumulator;
  assign o_status           = core_status_flags;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  bank_route_a : assert property (
    (i_acc_req && i_acc_addr == A_PORT1 && !eff_sfr && tbl_state != TS_STORE)
    |-> mem.addr[RAM_AW-1] == data_bank_select[B_BANK])
    else $error("indirect port 1 ignored bank select");

  bank_reset_a : assert property (
    (i_soft_reset && !i_wdt_pd_reset) |=> data_bank_select == RST_BANK)
    else $error("bank select not cleared by reset");

  bank_keep_a : assert property (
    (i_soft_reset && i_wdt_pd_reset && !sfr_wr) |=> $stable(data_bank_select))
    else $error("sleep time-out reset changed bank select");

  direct_bank0_a : assert property (
    (i_acc_req && i_acc_addr != A_PORT1 && !eff_sfr && tbl_state != TS_STORE)
    |-> mem.addr[RAM_AW-1] == 1'h0)
    else $error("direct access reached bank 1");

  status_top_a : assert property (
    (i_acc_req && !i_acc_wr && (i_acc_addr == A_STATUS || i_acc_addr == A_BANK))
    |=> ##1 o_rd_valid && o_rd_data[7:6] == 2'h0)
    else $error("upper status or bank bits read nonzero");

  pcl_jump_a : assert property (
    (sfr_wr && eff_addr == A_PCLO && !i_soft_reset)
    |=> o_pc == {$past(o_pc[PC_W-1:8]), $past(i_acc_wdata)} && o_dummy_cycle)
    else $error("pc low write did not jump within page");

  dummy_hold_a : assert property (
    (o_dummy_cycle && !i_soft_reset && !sfr_wr) |=> $stable(o_pc))
    else $error("pc advanced during dummy cycle");

  flags_guard_a : assert property (
    (sfr_wr && eff_addr == A_STATUS && !i_wdt_timeout && !i_watchdog_clear_instruction && !i_halt)
    |=> o_status[B_WTO] == $past(o_status[B_WTO]) && o_status[B_PWD] == $past(o_status[B_PWD]))
    else $error("status write altered watchdog or power-down flag");

  timeout_set_a : assert property (
    i_wdt_timeout |=> o_status[B_WTO])
    else $error("watchdog flag not set on time-out");

  halt_flags_a : assert property (
    (i_halt && !i_wdt_timeout && !i_watchdog_clear_instruction) |=> o_status[B_PWD] && !o_status[B_WTO])
    else $error("halt left wrong power-down or watchdog flag");

  zero_flag_a : assert property (
    ((alu_arith || alu_logic) && !sfr_wr && tbl_state != TS_STORE)
    |=> o_status[B_Z] == (o_work_accumulator == 8'h00))
    else $error("zero flag disagrees with accumulator");

  table_high_a : assert property (
    (i_tblrd && tbl_state == TS_IDLE && !i_soft_reset)
    |=> o_pmem_rd ##2 table_high_byte == {1'h0, $past(i_pmem_data[PM_W-1:8])})
    else $error("table high byte not loaded from fetched word");
endmodule : csr_core_regs

// *** tb/csr_core_regs_bench.sv ***
// self-checking bench of the core special register block
`timescale 1ns/1ps
module csr_core_regs_bench
  import csr_pkg::*;
();
  logic            clk, rst, srst, pdr, tmo, clr, hlt, req, wr, stp, trd, tacc;
  logic            rdv, pmr, dum;
  logic [7:0]      adr, wd, alb, rd, acc, st, sd, x, y, s;
  logic [PM_W-1:0] pmd;
  logic [PC_W-1:0] pma, pc;
  logic [15:0]     e;
  csr_alu_op_t     op;
  int              num_errors, checks, i;
  logic [15:0]     corner [3] = '{16'h7F01, 16'h8080, 16'h5555};

  csr_core_regs i_dut (.i_clk_sys(clk), .i_reset(rst), .i_soft_reset(srst),
    .i_wdt_pd_reset(pdr), .i_wdt_timeout(tmo), .i_watchdog_clear_instruction(clr), .i_halt(hlt),
    .i_acc_req(req), .i_acc_wr(wr), .i_acc_addr(adr), .i_acc_wdata(wd), .i_alu_op(op),
    .i_alu_b(alb), .i_step(stp), .i_tblrd(trd), .i_tbl_to_acc(tacc), .i_pmem_data(pmd),
    .o_rd_data(rd), .o_rd_valid(rdv), .o_pmem_addr(pma), .o_pmem_rd(pmr), .o_pc(pc),
    .o_dummy_cycle(dum), .o_work_accumulator(acc), .o_status(st));

  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr
  // expected {result, ov, z, ac, c} of an add or a subtract
  function automatic logic [15:0] alu(input logic sub, input logic [7:0] a, input logic [7:0] b);
    logic [8:0] r;
    logic [4:0] h;
    logic [7:0] bb;
    bb = sub ? ~b : b;
    r = a + bb + sub;
    h = a[3:0] + bb[3:0] + sub;
    return {4'h0, r[7:0], (a[7] == bb[7]) && (r[7] != a[7]), r[7:0] == 8'h00, h[4], r[8]};
  endfunction : alu
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected value at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {req, wr, adr, wd} = {2'b11, a, d};
    @(negedge clk);
    req = 0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a);
    int n;
    @(negedge clk);
    {req, wr, adr} = {2'b10, a};
    @(negedge clk);
    req = 0;
    for (n = 0; rdv !== 1'b1 && n < 4; n++) @(negedge clk);
    if (n == 4) num_errors++;
    sd = rd;
  endtask : rreg
  task automatic pulse(ref logic p);
    @(negedge clk);
    p = 1;
    @(negedge clk);
    p = 0;
  endtask : pulse
  task automatic alu_step(input csr_alu_op_t o, input logic [7:0] b);
    @(negedge clk);
    op = o;
    alb = b;
    @(negedge clk);
    op = OP_NONE;
  endtask : alu_step
  task automatic test_done;
    $display("checks %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done

  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    test_done();
  end
  initial begin
    {rst, srst, pdr, tmo, clr, hlt, req, wr, stp, trd, tacc} = 11'h400;
    {adr, wd, alb, pmd, s} = {39'h0, 8'h1D};
    op = OP_NONE;
    repeat (6) @(negedge clk);
    rst = 0;
    check(st, RST_ST);
    rreg(A_BANK);
    check(sd, RST_BANK);
    // arithmetic flags: corners first, then random operands
    for (i = 0; i < 24; i++) begin
      s = lfsr(s);
      x = (i < 3) ? corner[i][15:8] : s;
      s = lfsr(s);
      y = (i < 3) ? corner[i][7:0] : s;
      e = alu(i[0], x, y);
      wreg(A_ACCU, x);
      alu_step(i[0] ? OP_SUB : OP_ADD, y);
      check(acc, e[11:4]);
      check(st[3:0], e[3:0]);
    end
    wreg(A_STATUS, 8'h00);
    wreg(A_ACCU, 8'h01);
    alu_step(OP_RRC, 8'h00);
    check({acc, st[0]}, {8'h00, 1'b1});
    alu_step(OP_RLC, 8'h00);
    check({acc, st[0]}, {8'h01, 1'b0});
    wreg(A_ACCU, 8'hF0);
    alu_step(OP_AND, 8'h0F);
    check({acc, st[2]}, {8'h00, 1'b1});
    alu_step(OP_OR, 8'h3C);
    check({acc, st[2]}, {8'h3C, 1'b0});
    alu_step(OP_XOR, 8'h3C);
    check({acc, st[2]}, {8'h00, 1'b1});
    $display("test alu done");
    // system flags
    pulse(hlt);
    check(st[5:4], 2'b01);
    wreg(A_STATUS, 8'hEF);
    check(st, 8'h1F);
    pulse(tmo);
    check(st[5:4], 2'b11);
    pulse(clr);
    check(st[5:4], 2'b00);
    pulse(tmo);
    pulse(hlt);
    check(st[5:4], 2'b01);
    $display("test flags done");
    // banks: direct to bank 0, pointer port 1 to bank 1
    s = lfsr(s);
    x = s;
    y = ~s;
    wreg(A_BANK, 8'hFF);
    rreg(A_BANK);
    check(sd, 8'h01);
    wreg(A_GP_BASE, x);
    wreg(A_PTR1, A_GP_BASE);
    wreg(A_PORT1, y);
    rreg(A_GP_BASE);
    check(sd, x);
    rreg(A_PORT1);
    check(sd, y);
    wreg(A_PTR0, A_GP_BASE);
    rreg(A_PORT0);
    check(sd, x);
    wreg(A_PTR0, A_BANK);
    rreg(A_PORT0);
    check(sd, 8'h01);
    rreg(8'h09);
    check(sd, 8'h00);
    @(negedge clk);
    pdr = 1;
    pulse(srst);
    pdr = 0;
    rreg(A_PORT1);
    check(sd, y);
    pulse(srst);
    rreg(A_PORT1);
    check(sd, x);
    $display("test banks done");
    // page jump and table read from page 1
    @(negedge clk);
    stp = 1;
    repeat (300) @(negedge clk);
    stp = 0;
    wreg(A_PCLO, x);
    check({pc, dum}, {3'h1, x, 1'b1});
    stp = 1;
    @(negedge clk);
    stp = 0;
    check({pc, dum}, {3'h1, x, 1'b0});
    wreg(A_TPTR, y);
    @(negedge clk);
    {trd, tacc} = 2'b11;
    @(negedge clk);
    trd = 0;
    check({pmr, pma}, {1'b1, 3'h1, y});
    s = lfsr(s);
    pmd = {s[6:0], x};
    repeat (2) @(negedge clk);
    check(acc, x);
    rreg(A_THI);
    check(sd, {1'b0, s[6:0]});
    // low byte to a ram cell instead of the accumulator
    @(negedge clk);
    {trd, tacc, adr} = {2'b10, A_GP_BASE | 8'h01};
    @(negedge clk);
    trd = 0;
    pmd = {x[6:0], y};
    repeat (2) @(negedge clk);
    check(acc, x);
    rreg(A_GP_BASE | 8'h01);
    check(sd, y);
    rreg(A_THI);
    check(sd, {1'b0, x[6:0]});
    $display("test pc and table done");
    test_done();
  end
endmodule : csr_core_regs_bench
